// ---- rtl/msra_consts.svh ----
`ifndef MSRA_CONSTS_SVH
`define MSRA_CONSTS_SVH
// Frame field widths and codes for the serial management slave.
`define MSRA_PREAMBLE_LEN 6'h20
`define MSRA_FIELD_BITS 5
`define MSRA_DATA_BITS 16
`define MSRA_OP_READ 2'h2
`define MSRA_OP_WRITE 2'h1
`define MSRA_OP_EXT 2'h0
`define MSRA_PHY_EXT_READ_BIT 4
`define MSRA_EXT_LAST_ADDR 8'h8D
`define MSRA_STD_REG_29 5'h1D
`define MSRA_STD_REG_31 5'h1F
`define MSRA_STD_REG_MAX 5'h05
`define MSRA_PHY_ADDR_DEFAULT 5'h01
`define MSRA_CFG_RESET 8'h00
`define MSRA_STD_RESET 16'h0000
`endif

// ---- rtl/msra_pkg.sv ----
package msra_pkg;
    // Frame receive and answer states, Gray coded along the usual path.
    typedef enum logic [3:0] {
        MSRA_IDLE = 4'b0000,
        MSRA_PRE = 4'b0001,
        MSRA_ST = 4'b0011,
        MSRA_OP = 4'b0010,
        MSRA_PHY = 4'b0110,
        MSRA_REG = 4'b0111,
        MSRA_TA = 4'b0101,
        MSRA_DATA = 4'b0100
    } msra_state_t;
endpackage

// ---- rtl/msra_cfg_mem.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "msra_consts.svh"
// Byte-wide configuration store with a registered read port.
module msra_cfg_mem #(
    parameter int DEPTH = 142
) (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_reset_n,
    // Access port.
    input wire logic i_write,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    // Storage words; cleared by reset so reads are defined.
    logic [7:0] mem [DEPTH];

    // Writes beyond the depth are dropped; reads beyond it return zero.
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            for (int k = 0; k < DEPTH; k++) begin
                mem[k] <= `MSRA_CFG_RESET;
            end
            o_rdata <= `MSRA_CFG_RESET;
        end else begin
            if (i_write && (32'(i_addr) < DEPTH)) begin
                mem[i_addr] <= i_wdata;
            end
            o_rdata <= (32'(i_addr) < DEPTH) ? mem[i_addr] : `MSRA_CFG_RESET;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/msra_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
// Two flip-flop level synchroniser for a single bit.
module msra_sync (
    // Destination clock and reset.
    input wire logic i_clock,
    input wire logic i_reset_n,
    // Level in and synchronised level out.
    input wire logic i_level,
    output logic o_level
);
    // First stage is read only by the second stage.
    logic stage1;

    // Both stages clear on reset.
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            stage1 <= 1'b0;
            o_level <= 1'b0;
        end else begin
            stage1 <= i_level;
            o_level <= stage1;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/msra_mgmt_slave.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "msra_consts.svh"
module msra_mgmt_slave
    import msra_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = `MSRA_PHY_ADDR_DEFAULT,
    parameter int CFG_DEPTH = 142
) (
    // System clock and reset.
    input wire logic i_clock,
    input wire logic i_reset_n,
    // Management link, clocked by the controller.
    input wire logic i_mgmt_clock,
    input wire logic i_mgmt_data,
    output logic o_mgmt_data,
    output logic o_mgmt_data_oe_n,
    // Status on the system clock.
    output logic o_frame_busy,
    output logic [7:0] o_last_ext_addr
);
    // Link-side state, all in one struct.
    typedef struct packed {
        msra_state_t state;
        logic [5:0] count;
        logic [1:0] opcode;
        logic [4:0] phy;
        logic [4:0] reg_addr;
        logic [15:0] shift;
        logic is_read;
        logic is_ext;
        logic mine;
        logic drive;
        logic dout;
        logic [7:0][15:0] std_regs; // Packed so the whole state stays one packed struct.
        logic cfg_wr;
        logic [7:0] cfg_addr;
        logic [7:0] cfg_wdata;
    } msra_link_t;

    // Registered and next link state.
    msra_link_t link;
    msra_link_t next_link;
    // Link reset is the system reset brought into the link domain.
    logic link_reset_n;
    // Registered configuration read data.
    logic [7:0] cfg_rdata;
    // Busy level crossed to the system domain.
    logic busy_sync;

    // Maps a register number to one of the eight standard slots, or to 8 when it has none.
    function automatic logic [3:0] std_slot(input logic [4:0] r);
        logic [3:0] s;
        s = 4'h8;
        if (r <= `MSRA_STD_REG_MAX) begin
            s = {1'b0, r[2:0]};
        end else if (r == `MSRA_STD_REG_29) begin
            s = 4'h6;
        end else if (r == `MSRA_STD_REG_31) begin
            s = 4'h7;
        end
        return s;
    endfunction

    // Reset crosses into the link domain through two flops.
    msra_sync u_rst_sync (
        .i_clock(i_mgmt_clock),
        .i_reset_n(1'b1),
        .i_level(i_reset_n),
        .o_level(link_reset_n)
    );

    // Configuration bytes live in their own memory on the link clock.
    msra_cfg_mem #(
        .DEPTH(CFG_DEPTH)
    ) u_cfg (
        .i_clock(i_mgmt_clock),
        .i_reset_n(link_reset_n),
        .i_write(link.cfg_wr),
        .i_addr(next_link.cfg_addr),
        .i_wdata(link.cfg_wdata),
        .o_rdata(cfg_rdata)
    );

    // Frame decoder; the data pin is sampled on the rising link edge.
    // The pin is in the link clock's domain, so no synchroniser applies.
    always_comb begin
        logic [3:0] slot;
        slot = 4'h8;
        next_link = link;
        next_link.cfg_wr = 1'b0;
        unique case (link.state)
            MSRA_IDLE, MSRA_PRE: begin
                // Count consecutive ones; a zero after 32 is the start bit.
                next_link.drive = 1'b0;
                if (i_mgmt_data) begin
                    if (link.count != `MSRA_PREAMBLE_LEN) begin
                        next_link.count = link.count + 6'h01;
                    end
                    next_link.state = MSRA_PRE;
                end else if (link.count == `MSRA_PREAMBLE_LEN) begin
                    next_link.state = MSRA_ST;
                end else begin
                    next_link.count = 6'h00;
                    next_link.state = MSRA_IDLE;
                end
            end
            MSRA_ST: begin
                // Second start bit must be one, else the frame is abandoned.
                next_link.count = 6'h00;
                next_link.state = i_mgmt_data ? MSRA_OP : MSRA_IDLE;
            end
            MSRA_OP: begin
                // Two opcode bits, most significant first.
                next_link.opcode = {link.opcode[0], i_mgmt_data};
                next_link.count = link.count + 6'h01;
                if (link.count == 6'h01) begin
                    next_link.count = 6'h00;
                    next_link.state = MSRA_PHY;
                end
            end
            MSRA_PHY: begin
                // Five PHY address bits.
                next_link.phy = {link.phy[3:0], i_mgmt_data};
                next_link.count = link.count + 6'h01;
                if (link.count == 6'h04) begin
                    next_link.count = 6'h00;
                    next_link.state = MSRA_REG;
                end
            end
            MSRA_REG: begin
                // Five register address bits, then classify the access.
                next_link.reg_addr = {link.reg_addr[3:0], i_mgmt_data};
                next_link.count = link.count + 6'h01;
                if (link.count == 6'h04) begin
                    next_link.count = 6'h00;
                    next_link.state = MSRA_TA;
                    next_link.is_ext = (link.opcode == `MSRA_OP_EXT);
                    // Bit 4 picks read or write; bit 3 is ignored.
                    next_link.is_read = next_link.is_ext ?
                        link.phy[`MSRA_PHY_EXT_READ_BIT] : (link.opcode == `MSRA_OP_READ);
                    next_link.mine = next_link.is_ext || (link.phy == PHY_ADDR &&
                        (link.opcode == `MSRA_OP_READ || link.opcode == `MSRA_OP_WRITE));
                    // Extended address joins PHY[2:0] with REG[4:0].
                    next_link.cfg_addr = {link.phy[2:0], next_link.reg_addr};
                end
            end
            MSRA_TA: begin
                // Read: release first bit, drive zero on the second.
                next_link.count = link.count + 6'h01;
                if (link.count == 6'h00) begin
                    if (link.is_read && link.mine) begin
                        next_link.drive = 1'b1;
                        next_link.dout = 1'b0;
                    end
                end else begin
                    next_link.count = 6'h00;
                    next_link.state = MSRA_DATA;
                    if (link.is_ext) begin
                        // Upper byte reads as zero, lower byte from store.
                        next_link.shift = {8'h00, cfg_rdata};
                        slot = std_slot(link.cfg_addr[4:0]);
                        if (link.cfg_addr[7:5] == 3'h7 && slot != 4'h8 &&
                                link.cfg_addr > `MSRA_EXT_LAST_ADDR) begin
                            // Standard registers reached indirectly above the map.
                            next_link.shift = {8'h00, link.std_regs[slot[2:0]][7:0]};
                        end
                    end else begin
                        slot = std_slot(link.reg_addr);
                        // Unimplemented standard registers read zero.
                        next_link.shift = (slot == 4'h8) ? `MSRA_STD_RESET :
                            link.std_regs[slot[2:0]];
                    end
                    if (link.is_read && link.mine) begin
                        next_link.dout = next_link.shift[15];
                    end
                end
            end
            MSRA_DATA: begin
                // Sixteen data bits, MSB first, shifted out or in.
                if (link.is_read) begin
                    next_link.shift = {link.shift[14:0], 1'b0};
                    next_link.dout = link.shift[14];
                end else begin
                    next_link.shift = {link.shift[14:0], i_mgmt_data};
                end
                next_link.count = link.count + 6'h01;
                if (link.count == 6'h0F) begin
                    // Line released for idle after the last bit.
                    next_link.drive = 1'b0;
                    next_link.count = 6'h00;
                    next_link.state = MSRA_IDLE;
                    if (!link.is_read && link.mine) begin
                        if (link.is_ext) begin
                            // Only the low byte is kept.
                            next_link.cfg_wr = 1'b1;
                            next_link.cfg_wdata = next_link.shift[7:0];
                        end else begin
                            slot = std_slot(link.reg_addr);
                            if (slot != 4'h8) begin
                                next_link.std_regs[slot[2:0]] = next_link.shift;
                            end
                        end
                    end
                end
            end
        endcase
    end

    // Link-domain state register.
    always_ff @(posedge i_mgmt_clock) begin
        if (!link_reset_n) begin
            link <= '0;
        end else begin
            link <= next_link;
        end
    end

    // Pin driven only during read turnaround and data; enable is low when driving.
    assign o_mgmt_data = link.dout;
    assign o_mgmt_data_oe_n = ~link.drive;

    // Frame activity crosses to the system domain as a level.
    msra_sync u_busy_sync (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_level(link.state != MSRA_IDLE && link.state != MSRA_PRE),
        .o_level(busy_sync)
    );

    // System-side status registers; address only sampled while idle so it is stable.
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_frame_busy <= 1'b0;
            o_last_ext_addr <= 8'h00;
        end else begin
            o_frame_busy <= busy_sync;
            if (!busy_sync) begin
                o_last_ext_addr <= link.cfg_addr;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/msra_mgmt_slave_props.sv ----
`timescale 1ns/10ps
`default_nettype none
// Ties the data line outputs to the frame bits the device has just seen.
module msra_mgmt_slave_props #(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    // Watched ports.
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_mgmt_clock,
    input wire logic i_mgmt_data,
    input wire logic o_mgmt_data,
    input wire logic o_mgmt_data_oe_n,
    input wire logic o_frame_busy,
    input wire logic [7:0] o_last_ext_addr
);
    logic [12:0] hist; // Last line bits: opcode, both addresses, first turnaround bit.
    logic [4:0] cnt; // Link periods the device has driven so far.
    logic ext_rd; // The frame being answered is an extended read.
    logic rd_ok;
    assign rd_ok = (hist[12:11] == 2'b10 && hist[10:6] == PHY_ADDR) ||
                   (hist[12:11] == 2'b00 && hist[10]);
    // Helper state; ext_rd is latched as the device starts to drive.
    always_ff @(posedge i_mgmt_clock) begin
        hist <= {hist[11:0], i_mgmt_data};
        cnt <= o_mgmt_data_oe_n ? 5'h00 : cnt + 5'h01;
        if (!i_reset_n) begin
            ext_rd <= 1'b0;
        end else if ($fell(o_mgmt_data_oe_n)) begin
            ext_rd <= (hist[12:11] == 2'b00);
        end
    end
    a_ta_zero: assert property (@(posedge i_mgmt_clock) disable iff (!i_reset_n)
        $fell(o_mgmt_data_oe_n) |-> !o_mgmt_data) else $error("turnaround bit not zero");
    a_drive_reads_only: assert property (@(posedge i_mgmt_clock) disable iff (!i_reset_n)
        $fell(o_mgmt_data_oe_n) |-> rd_ok) else $error("line driven on a non-read frame");
    a_drive_span: assert property (@(posedge i_mgmt_clock) disable iff (!i_reset_n)
        !o_mgmt_data_oe_n |-> cnt <= 5'h10) else $error("line driven too long");
    a_release_time: assert property (@(posedge i_mgmt_clock) disable iff (!i_reset_n)
        $rose(o_mgmt_data_oe_n) |-> cnt == 5'h11) else $error("line released early");
    a_upper_zero: assert property (@(posedge i_mgmt_clock) disable iff (!i_reset_n)
        ext_rd && !o_mgmt_data_oe_n && cnt >= 5'h01 && cnt <= 5'h08 |-> !o_mgmt_data)
        else $error("upper byte not zero");
    a_idle_release: assert property (@(posedge i_mgmt_clock) disable iff (!i_reset_n)
        $rose(o_mgmt_data_oe_n) |-> o_mgmt_data_oe_n [*8]) else $error("line taken again");
    a_reset_quiet: assert property (@(posedge i_mgmt_clock)
        !i_reset_n [*4] |=> o_mgmt_data_oe_n) else $error("line driven in reset");
    a_addr_quiet: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        $changed(o_last_ext_addr) |-> !o_frame_busy) else $error("address moved while busy");
    c_ext_read: cover property (@(posedge i_mgmt_clock) disable iff (!i_reset_n)
        $fell(o_mgmt_data_oe_n) && hist[12:11] == 2'b00);
    c_std_read: cover property (@(posedge i_mgmt_clock) disable iff (!i_reset_n)
        $fell(o_mgmt_data_oe_n) && hist[12:11] == 2'b10);
    c_release: cover property (@(posedge i_mgmt_clock) disable iff (!i_reset_n)
        $rose(o_mgmt_data_oe_n));
endmodule
bind msra_mgmt_slave msra_mgmt_slave_props #(.PHY_ADDR(PHY_ADDR)) i_props (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_mgmt_clock(i_mgmt_clock),
    .i_mgmt_data(i_mgmt_data), .o_mgmt_data(o_mgmt_data), .o_mgmt_data_oe_n(o_mgmt_data_oe_n),
    .o_frame_busy(o_frame_busy), .o_last_ext_addr(o_last_ext_addr));
`default_nettype wire

// ---- verification/msra_ctrl_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Management controller: makes the link clock and owns its side of the line.
module msra_ctrl_model (
    // Link toward the device.
    output logic o_mgmt_clock,
    output logic o_mgmt_data,
    input wire logic i_dev_data,
    input wire logic i_dev_oe_n
);
    logic drv; // Controller drives the line while high.
    logic val;
    // Shared line: a released line is lifted to one by its pull-up.
    assign o_mgmt_data = !i_dev_oe_n ? i_dev_data : (drv ? val : 1'b1);
    initial begin
        o_mgmt_clock = 1'b0;
        drv = 1'b0;
        val = 1'b0;
    end
    // One period; sampled just ahead of the rising edge to avoid a race.
    task automatic bit_io(input logic d, input logic v, output logic seen);
        drv = d;
        val = v;
        #15 seen = o_mgmt_data;
        #1 o_mgmt_clock = 1'b1;
        #16 o_mgmt_clock = 1'b0;
    endtask
    task automatic run_clocks(input int n);
        logic s;
        repeat (n) bit_io(1'b0, 1'b0, s);
    endtask
    // One whole frame; the clock stands still again afterwards.
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
            input logic [15:0] wd, output logic [15:0] rd, output logic ta);
        logic [13:0] hdr;
        logic s;
        logic is_rd;
        hdr = {2'b01, op, phy, rg};
        is_rd = op == 2'b10 || (op == 2'b00 && phy[4]);
        repeat (32) bit_io(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) bit_io(1'b1, hdr[i], s);
        bit_io(!is_rd, 1'b1, s);
        bit_io(!is_rd, 1'b0, ta);
        for (int i = 15; i >= 0; i--) bit_io(!is_rd, wd[i], rd[i]);
        drv = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- verification/test_mgmt_serial_register_access.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin errors++; $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module test_mgmt_serial_register_access;
    logic i_clock;
    logic i_reset_n;
    logic mgmt_clock;
    logic mgmt_din;
    logic mgmt_dout;
    logic mgmt_oe_n;
    logic frame_busy;
    logic [7:0] last_ext_addr;
    int errors;
    int total_checks;
    logic [15:0] rd;
    logic ta;
    logic [4:0] std_regs [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h1D, 5'h1F};
    logic [7:0] ext_addrs [3] = '{8'h00, 8'h8D, 8'h47}; // Both ends of the range and a middle one.
    msra_mgmt_slave #(.PHY_ADDR(5'h01), .CFG_DEPTH(142)) i_dut (
        .i_clock(i_clock), .i_reset_n(i_reset_n), .i_mgmt_clock(mgmt_clock),
        .i_mgmt_data(mgmt_din), .o_mgmt_data(mgmt_dout), .o_mgmt_data_oe_n(mgmt_oe_n),
        .o_frame_busy(frame_busy), .o_last_ext_addr(last_ext_addr));
    msra_ctrl_model i_ctrl (.o_mgmt_clock(mgmt_clock), .o_mgmt_data(mgmt_din),
        .i_dev_data(mgmt_dout), .i_dev_oe_n(mgmt_oe_n));
    always #50 i_clock = ~i_clock;
    // The busy flag lags the link by a few clocks, so it is polled with a bound.
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (4) @(negedge i_clock);
        while (frame_busy !== 1'b0 && n < 50) begin
            @(negedge i_clock);
            n++;
        end
        if (n >= 50) begin
            errors++;
            final_report();
        end
    endtask
    // Standard registers hold all 16 bits; a foreign address is never answered.
    task automatic test_std();
        foreach (std_regs[i]) i_ctrl.frame(2'b01, 5'h01, std_regs[i], {8'hA5, 3'h0, std_regs[i]}, rd, ta);
        foreach (std_regs[i]) begin
            i_ctrl.frame(2'b10, 5'h01, std_regs[i], 16'h0000, rd, ta);
            `CHK("std ta", 1'b0, ta)
            `CHK("std data", {8'hA5, 3'h0, std_regs[i]}, rd)
        end
        i_ctrl.frame(2'b10, 5'h02, 5'h00, 16'h0000, rd, ta);
        `CHK("other phy", 16'hFFFF, rd)
        $display("test_std done");
    endtask
    // Extended writes carry junk in bit 3 and the upper byte; reads flip bit 3.
    task automatic test_ext();
        logic [7:0] a;
        foreach (ext_addrs[i]) begin
            a = ext_addrs[i];
            i_ctrl.frame(2'b00, {2'b01, a[7:5]}, a[4:0], {8'hFF, a ^ 8'h5A}, rd, ta);
            wait_idle();
            `CHK("ext addr", a, last_ext_addr)
            i_ctrl.frame(2'b00, {2'b10, a[7:5]}, a[4:0], 16'h0000, rd, ta);
            `CHK("ext data", {8'h00, a ^ 8'h5A}, rd)
        end
        i_ctrl.frame(2'b00, 5'h17, 5'h1F, 16'h0000, rd, ta);
        `CHK("indirect", 16'h001F, rd)
        $display("test_ext done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Link clock toggles during reset so its synchronised reset takes hold.
    initial begin
        i_clock = 1'b0;
        i_reset_n = 1'b0;
        errors = 0;
        total_checks = 0;
        #7;
        fork
            repeat (5) @(negedge i_clock);
            i_ctrl.run_clocks(16);
        join
        @(negedge i_clock);
        i_reset_n = 1'b1;
        i_ctrl.run_clocks(4);
        test_std();
        test_ext();
        final_report();
    end
endmodule
`default_nettype wire
